// ---- src/ipw_top.sv ----
/*
  Interrupt routing, priority storage and stop-mode wake for a small
  microcontroller. Maps peripheral events to request numbers, holds
  2-bit priorities, keeps pending bits and asks clock control to restart.
  Assumes peripheral events are level or edge signals synchronous to CLK
  while running, and that clock control reports restart with CLK_RUN.
*/
// Contract
// - Vector slot equals request number plus sixteen.
// - Comparator either edge raises request 16, vector 32.
// - Timer modules raise requests 17 and 18 for overflow or channel.
// - Low-power timer compare match raises request 28, vector 44.
// - Priority register index is request divided by four.
// - Field starts at eight times request mod four plus six.
// - Priority fields are two bits, four levels.
// - Wake detected without clock in stop, clock restart requested.
// - After restart, wake request seen pending and handled.
// - Any enabled pin interrupt wakes from stop.
// - Low-voltage detect and warning wake from stop.
// - Comparator wakes in normal and trigger mode.
// - Two-wire address match wakes from stop.
// - Clock alarm, seconds and non-maskable pin wake from stop.
// - Serial, timer and low-power timer wake only when clocked.
// - Wake works only down to very low power stop.
`timescale 1ns/1ps
`default_nettype none
`include "ipw_regs.svh"

module ipw_top
  import ipw_pkg::*;
#(
  parameter int NUM_IRQ = `IPW_NUM_IRQ
) (
  input  wire logic                CLK,
  input  wire logic                ARST_N,
  input  wire ipw_src_t            SRC,
  input  wire ipw_clkon_t          SRC_CLKON,
  input  wire logic                CMP_TRIG_MODE,
  input  wire logic [NUM_IRQ-1:0]  IRQ_EN,
  input  wire ipw_pwr_t            PWR_MODE,
  input  wire logic                CLK_RUN,
  input  wire ipw_pwr_req_t        PRIO_WR,
  input  wire logic                ACK_EN,
  input  wire logic [4:0]          ACK_IRQ,
  output logic [NUM_IRQ-1:0]       IRQ_PEND,
  output logic [255:0]             PRIO_REGS,
  output logic                     NMI_PEND,
  output logic [5:0]               TOP_VECTOR,
  output logic                     TOP_VALID,
  output logic                     CLK_RESTART_REQ
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_IRQ-1:0] pend;
    logic [255:0]       prio;
    logic               cmp_prev;
    logic               nmi_prev;
    logic               nmi_pend;
    logic [5:0]         vec;
    logic               vec_ok;
    logic               restart;
  } ipw_state_t;

  ipw_state_t st_ff;
  ipw_state_t nxt_st;

  logic [NUM_IRQ-1:0] raw_irq;
  logic [NUM_IRQ-1:0] wake_src;
  logic               stop_ok;
  logic               in_stop;
  logic               wake_req;
  logic               wake;

  // ----------------------------------------------------------------
  // Priority field addressing
  // ----------------------------------------------------------------
  // register index
  function automatic logic [2:0] prio_reg_idx(input logic [4:0] irq);
    prio_reg_idx = irq[4:2];
  endfunction

  function automatic logic [4:0] prio_bit_pos(input logic [4:0] irq);
    logic [5:0] pos;
    pos = 6'(`IPW_PRIO_STRIDE) * {4'h0, irq[1:0]} + 6'(`IPW_PRIO_BASE);
    prio_bit_pos = pos[4:0];
  endfunction

  function automatic logic [5:0] vec_of(input logic [4:0] irq);
    vec_of = {1'b0, irq} + 6'(`IPW_VEC_OFFSET);
  endfunction

  // ----------------------------------------------------------------
  // Source mapping
  // ----------------------------------------------------------------
  always_comb begin
    raw_irq = '0;
    raw_irq[`IPW_IRQ_CMP] = SRC.cmp_out ^ st_ff.cmp_prev;
    raw_irq[`IPW_IRQ_TPM_FIRST]  = SRC.timer_pwm_first_ovf
                                   | (|SRC.timer_pwm_first_ch);
    raw_irq[`IPW_IRQ_TPM_SECOND] = SRC.timer_pwm_second_ovf
                                   | (|SRC.timer_pwm_second_ch);
    raw_irq[`IPW_IRQ_LPTMR]     = SRC.lptmr_match;
    raw_irq[`IPW_IRQ_RTC_ALARM] = SRC.rtc_alarm;
    raw_irq[`IPW_IRQ_RTC_SEC]   = SRC.rtc_sec;
    raw_irq[`IPW_IRQ_PMC]       = SRC.lvd | SRC.lvw;
    raw_irq[`IPW_IRQ_I2C]       = SRC.i2c_addr_match;
    raw_irq[`IPW_IRQ_SERIAL]    = SRC.serial_irq;
    raw_irq[`IPW_IRQ_PORTA]     = SRC.porta_pin;
    raw_irq[`IPW_IRQ_PORTB]     = SRC.portb_pin;
  end

  // ----------------------------------------------------------------
  // Wake sources
  // ----------------------------------------------------------------
  always_comb begin
    wake_src = '0;
    wake_src[`IPW_IRQ_PORTA] = SRC.porta_pin;
    wake_src[`IPW_IRQ_PORTB] = SRC.portb_pin;
    wake_src[`IPW_IRQ_PMC] = SRC.lvd | SRC.lvw;
    wake_src[`IPW_IRQ_CMP] = SRC.cmp_out ^ (st_ff.cmp_prev & ~CMP_TRIG_MODE)
                             | (CMP_TRIG_MODE & SRC.cmp_out);
    wake_src[`IPW_IRQ_I2C] = SRC.i2c_addr_match;
    wake_src[`IPW_IRQ_RTC_ALARM] = SRC.rtc_alarm;
    wake_src[`IPW_IRQ_RTC_SEC]   = SRC.rtc_sec;
    wake_src[`IPW_IRQ_SERIAL] = SRC.serial_irq & SRC_CLKON.serial;
    wake_src[`IPW_IRQ_TPM_FIRST] = raw_irq[`IPW_IRQ_TPM_FIRST]
                                   & SRC_CLKON.timer_pwm_first;
    wake_src[`IPW_IRQ_TPM_SECOND] = raw_irq[`IPW_IRQ_TPM_SECOND]
                                    & SRC_CLKON.timer_pwm_second;
    wake_src[`IPW_IRQ_LPTMR] = SRC.lptmr_match & SRC_CLKON.lptmr;
  end

  // no deeper than very low power stop
  assign stop_ok = (PWR_MODE == IPW_STOP)
                   || (PWR_MODE == IPW_VERY_LOW_POWER_STOP);
  assign in_stop = stop_ok & ~CLK_RUN;
  assign wake_req = in_stop & ((|(wake_src & IRQ_EN)) | ~SRC.nmi_pin_n);

  ipw_wake_latch u_wake (
    .clk      (CLK),
    .arst_n   (ARST_N),
    .wake_req (wake_req),
    .clr      (CLK_RUN),
    .wake     (wake)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [4:0]         pos;
    logic [7:0]         base;
    logic [NUM_IRQ-1:0] clr;
    nxt_st = st_ff;
    pos    = '0;
    base   = '0;
    clr    = '0;
    nxt_st.cmp_prev = SRC.cmp_out;
    nxt_st.nmi_prev = SRC.nmi_pin_n;
    // request clock restart
    // Registered, so it shows at the first edge of the restarted clock
    nxt_st.restart = wake & ~CLK_RUN;
    if (ACK_EN) begin
      clr[ACK_IRQ] = 1'b1;
    end
    // pending after restart; set wins over clear
    nxt_st.pend = (st_ff.pend & ~clr) | (raw_irq & IRQ_EN);
    // sticky capture of a falling non-maskable pin
    nxt_st.nmi_pend = st_ff.nmi_pend | (st_ff.nmi_prev & ~SRC.nmi_pin_n);
    if (PRIO_WR.en) begin
      pos  = prio_bit_pos(PRIO_WR.irq);
      base = {prio_reg_idx(PRIO_WR.irq), 5'h00};
      nxt_st.prio[8'(base + {3'h0, pos}) +: `IPW_PRIO_W] = PRIO_WR.prio;
    end
    nxt_st.vec_ok = 1'b0;
    nxt_st.vec    = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (nxt_st.pend[i]) begin
        nxt_st.vec_ok = 1'b1;
        nxt_st.vec    = vec_of(5'(i));
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_ff <= '{pend: '0, prio: '0, cmp_prev: 1'b0, nmi_prev: 1'b1,
                 nmi_pend: 1'b0, vec: '0, vec_ok: 1'b0, restart: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign IRQ_PEND        = st_ff.pend;
  assign PRIO_REGS       = st_ff.prio;
  assign NMI_PEND        = st_ff.nmi_pend;
  assign TOP_VECTOR      = st_ff.vec;
  assign TOP_VALID       = st_ff.vec_ok;
  assign CLK_RESTART_REQ = st_ff.restart;

endmodule

`default_nettype wire

// ---- common/ipw_regs.svh ----
/*
  Constants for the interrupt routing and stop-wake block: request numbers,
  vector offsets, priority field placement and wake source bit positions.
  Assumes nothing beyond inclusion by the package and design files.
*/
`ifndef IPW_REGS_SVH
`define IPW_REGS_SVH

// ----------------------------------------------------------------
// Request and vector numbering
// ----------------------------------------------------------------
`define IPW_NUM_IRQ        32
`define IPW_VEC_OFFSET     16
`define IPW_IRQ_CMP        16
`define IPW_IRQ_TPM_FIRST  17
`define IPW_IRQ_TPM_SECOND 18
`define IPW_IRQ_RTC_ALARM  20
`define IPW_IRQ_RTC_SEC    21
`define IPW_IRQ_LPTMR      28
`define IPW_IRQ_PORTA      30
`define IPW_IRQ_PORTB      31
`define IPW_IRQ_PMC        6
`define IPW_IRQ_I2C        8
`define IPW_IRQ_SERIAL     12

// ----------------------------------------------------------------
// Priority field placement
// ----------------------------------------------------------------
`define IPW_PRIO_PER_REG   4
`define IPW_PRIO_STRIDE    8
`define IPW_PRIO_BASE      6
`define IPW_PRIO_W         2
`define IPW_NUM_PRIO_REG   8
`define IPW_PRIO_RST       2'h0

`endif

// ---- common/ipw_pkg.sv ----
/*
  Types for the interrupt routing and stop-wake block.
  Assumes ipw_regs.svh is on the include path.
*/
`include "ipw_regs.svh"

package ipw_pkg;

  typedef enum logic [1:0] {
    IPW_RUN,
    IPW_STOP,
    IPW_VERY_LOW_POWER_STOP,
    IPW_DEEP
  } ipw_pwr_t;

  // Raw peripheral events
  typedef struct packed {
    logic       cmp_out;
    logic       timer_pwm_first_ovf;
    logic [1:0] timer_pwm_first_ch;
    logic       timer_pwm_second_ovf;
    logic [1:0] timer_pwm_second_ch;
    logic       lptmr_match;
    logic       rtc_alarm;
    logic       rtc_sec;
    logic       lvd;
    logic       lvw;
    logic       i2c_addr_match;
    logic       serial_irq;
    logic       porta_pin;
    logic       portb_pin;
    logic       nmi_pin_n;
  } ipw_src_t;

  // Clock status of sources that need a clock to run in stop mode
  typedef struct packed {
    logic serial;
    logic timer_pwm_first;
    logic timer_pwm_second;
    logic lptmr;
  } ipw_clkon_t;

  // Priority write request from the core
  typedef struct packed {
    logic       en;
    logic [4:0] irq;
    logic [1:0] prio;
  } ipw_pwr_req_t;

endpackage

// ---- src/ipw_wake_latch.sv ----
/*
  Asynchronous wake latch: captures any enabled wake request while the
  system clock is stopped, and is cleared by the clocked side.
  Assumes the wake request is glitch free; its source need not hold it.
*/
`timescale 1ns/1ps
`default_nettype none

module ipw_wake_latch (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic wake_req,
  input  wire logic clr,
  output var  logic wake
);

  logic set_ff;
  logic clr_ff;

  // ----------------------------------------------------------------
  // Clockless capture
  // ----------------------------------------------------------------
  // clockless wake capture
  always_ff @(posedge wake_req or negedge arst_n) begin
    if (!arst_n) begin
      set_ff <= 1'b0;
    end else begin
      set_ff <= ~clr_ff;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clr_ff <= 1'b0;
    end else begin
      // Acknowledge only while running, so a short wake pulse stays
      // latched until the clock has restarted
      clr_ff <= clr ? set_ff : clr_ff;
    end
  end

  assign wake = (set_ff ^ clr_ff) | wake_req;

endmodule

`default_nettype wire

// ---- test/ipw_chk.sv ----
/* Checker of ipw_top: pending, vector, priority and wake relations.
   Sees only ipw_top ports; bound to every ipw_top at the foot. */
`timescale 1ns/1ps
`default_nettype none
module ipw_chk
  import ipw_pkg::*;
#(
  parameter int NUM_IRQ = 32
) (
  input wire logic               CLK,
  input wire logic               ARST_N,
  input wire ipw_src_t           SRC,
  input wire logic [NUM_IRQ-1:0] IRQ_EN,
  input wire ipw_pwr_t           PWR_MODE,
  input wire logic               CLK_RUN,
  input wire ipw_pwr_req_t       PRIO_WR,
  input wire logic               ACK_EN,
  input wire logic [4:0]         ACK_IRQ,
  input wire logic [NUM_IRQ-1:0] IRQ_PEND,
  input wire logic [255:0]       PRIO_REGS,
  input wire logic               NMI_PEND,
  input wire logic [5:0]         TOP_VECTOR,
  input wire logic               TOP_VALID,
  input wire logic               CLK_RESTART_REQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  function automatic logic [5:0] low_vec(logic [31:0] p);
    low_vec = 6'h00;
    for (int i = 31; i >= 0; i--)
      if (p[i]) low_vec = 6'(i + 16);
  endfunction
  function automatic int fpos(logic [4:0] q);
    fpos = 32 * (q / 4) + 8 * (q % 4) + 6;
  endfunction
  sequence s_stop_evt;
    PWR_MODE == IPW_STOP && !CLK_RUN && SRC.lvd && IRQ_EN[6];
  endsequence
  sequence s_restart;
    ##[1:2] CLK_RESTART_REQ;
  endsequence
  a_vec_plus16: assert property (TOP_VALID |->
    TOP_VECTOR == low_vec(32'(IRQ_PEND))) else $error("bad top vector");
  a_valid_any: assert property (TOP_VALID == (|IRQ_PEND))
    else $error("top valid wrong");
  a_lptmr_pend: assert property (SRC.lptmr_match && IRQ_EN[28]
    |=> IRQ_PEND[28]) else $error("match not pending");
  a_tpm_pend: assert property ((SRC.timer_pwm_second_ovf
    || |SRC.timer_pwm_second_ch) && IRQ_EN[18] |=> IRQ_PEND[18])
    else $error("timer not pending");
  a_pend_hold: assert property (IRQ_PEND[28]
    && !(ACK_EN && ACK_IRQ == 5'h1c) |=> IRQ_PEND[28])
    else $error("pending lost");
  a_ack_clear: assert property (ACK_EN && ACK_IRQ == 5'h1c
    && !SRC.lptmr_match |=> !IRQ_PEND[28]) else $error("ack ignored");
  a_dis_never: assert property (!IRQ_EN[28] && !IRQ_PEND[28]
    |=> !IRQ_PEND[28]) else $error("disabled request pending");
  a_prio_field: assert property (PRIO_WR.en |=>
    PRIO_REGS[fpos($past(PRIO_WR.irq)) +: 2] == $past(PRIO_WR.prio))
    else $error("priority field wrong");
  a_prio_still: assert property (!PRIO_WR.en |=>
    $stable(PRIO_REGS)) else $error("priority changed unasked");
  a_run_clear: assert property (CLK_RUN |=> !CLK_RESTART_REQ)
    else $error("restart request while running");
  a_wake_req: assert property (s_stop_evt |-> s_restart)
    else $error("no restart request");
  a_nmi_fall: assert property ($fell(SRC.nmi_pin_n)
    |-> ##[1:2] NMI_PEND) else $error("nmi not pending");
endmodule
bind ipw_top ipw_chk #(.NUM_IRQ(NUM_IRQ)) u_chk (.CLK(CLK), .ARST_N(ARST_N),
  .SRC(SRC), .IRQ_EN(IRQ_EN), .PWR_MODE(PWR_MODE), .CLK_RUN(CLK_RUN),
  .PRIO_WR(PRIO_WR), .ACK_EN(ACK_EN), .ACK_IRQ(ACK_IRQ),
  .IRQ_PEND(IRQ_PEND), .PRIO_REGS(PRIO_REGS), .NMI_PEND(NMI_PEND),
  .TOP_VECTOR(TOP_VECTOR), .TOP_VALID(TOP_VALID),
  .CLK_RESTART_REQ(CLK_RESTART_REQ));
`default_nettype wire

// ---- test/ipw_core_model.sv ----
/* Core model: services the top pending request after lat cycles.
   Assumes valid and vector come from TOP_VALID and TOP_VECTOR. */
`timescale 1ns/1ps
`default_nettype none
module ipw_core_model (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       on,
  input  wire logic [3:0] lat,
  input  wire logic       valid,
  input  wire logic [5:0] vector,
  output var  logic       ack_en,
  output var  logic [4:0] ack_irq
);
  logic [3:0] cnt_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= 4'h0;
      ack_en <= 1'b0;
      ack_irq <= 5'h00;
    end else begin
      ack_en <= 1'b0;
      ack_irq <= ~ack_irq;
      cnt_ff <= 4'h0;
      if (on && valid && !ack_en) begin
        cnt_ff <= cnt_ff + 4'h1;
        if (cnt_ff >= lat) begin
          ack_en <= 1'b1;
          ack_irq <= 5'(vector - 6'h10);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/ipw_top_tb_top.sv ----
/* Testbench of ipw_top: mapping, pending, priority and stop wake.
   Assumes ipw_pkg, ipw_chk and ipw_core_model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin \
  total_checks++; \
  if ((s) !== (e)) begin \
    fails++; \
    $display("FAIL %s exp %h got %h", n, e, s); \
  end \
end
module ipw_top_tb_top;
  import ipw_pkg::*;
  localparam int IRQS [12] = '{16, 17, 18, 20, 21, 28, 30, 31, 6, 6, 8, 12};
  localparam logic [16:0] EVS [12] = '{17'h10000, 17'h08000, 17'h00800,
    17'h00100, 17'h00080, 17'h00200, 17'h00004, 17'h00002, 17'h00040,
    17'h00020, 17'h00010, 17'h00008};
  logic         ck = 1'b0, gate = 1'b1, run = 1'b0, trig = 1'b0;
  logic         on = 1'b0, arst_n = 1'b0;
  ipw_src_t     src = 17'h00001;
  ipw_clkon_t   clkon = 4'h0;
  ipw_pwr_t     pwr = IPW_RUN;
  ipw_pwr_req_t pw = 8'h00;
  logic [31:0]  en = 32'h0, pend;
  logic [255:0] prio, exp_prio = '0;
  logic         nmi, tv, req, ack_en;
  logic [5:0]   vec;
  logic [4:0]   ack_irq;
  logic [3:0]   lat = 4'h2;
  int           fails = 0, total_checks = 0, seed = 93, cyc = 0;
  ipw_top #(.NUM_IRQ(32)) dut (.CLK(ck), .ARST_N(arst_n), .SRC(src),
    .SRC_CLKON(clkon), .CMP_TRIG_MODE(trig), .IRQ_EN(en), .PWR_MODE(pwr),
    .CLK_RUN(run), .PRIO_WR(pw), .ACK_EN(ack_en), .ACK_IRQ(ack_irq),
    .IRQ_PEND(pend), .PRIO_REGS(prio), .NMI_PEND(nmi), .TOP_VECTOR(vec),
    .TOP_VALID(tv), .CLK_RESTART_REQ(req));
  ipw_core_model core (.clk(ck), .arst_n(arst_n), .on(on), .lat(lat),
    .valid(tv), .vector(vec), .ack_en(ack_en), .ack_irq(ack_irq));
  initial forever #2 ck = gate ? ~ck : 1'b0;
  function automatic int fpos(logic [4:0] q);
    fpos = 32 * (q / 4) + 8 * (q % 4) + 6;
  endfunction
  task automatic print_verdict();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge ck) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic tick(int n = 1);
    repeat (n) @(posedge ck);
    #1;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 40 && tv !== 1'b0; i++) tick();
    `CHK("idle", 1'b0, tv)
  endtask
  // One event in run mode, its request enabled or not
  task automatic fire(int k, bit e);
    logic [31:0] m;
    m = 32'h1 << IRQS[k];
    en = ($random(seed) & ~m) | (e ? m : 32'h0);
    lat = 4'($random(seed)) & 4'h7;
    src = src ^ EVS[k];
    tick();
    if (k != 0) src = src ^ EVS[k];
    tick();
    `CHK("pend", e ? m : 32'h0, pend)
    if (e) `CHK("vector", 6'(IRQS[k] + 16), vec)
    wait_idle();
  endtask
  // Event during stopped clock; y says whether it must wake
  task automatic wake(int k, ipw_pwr_t md, bit c, bit t, bit y);
    on = 1'b0;
    en = 32'h1 << IRQS[k];
    pwr = md;
    clkon = {c, c, c, c};
    trig = t;
    run = 1'b0;
    tick();
    gate = 1'b0;
    #20 src = src ^ EVS[k];
    #20 if (!y) src = src ^ EVS[k];
    gate = 1'b1;
    tick(3);
    `CHK("restart", y, req)
    run = 1'b1;
    tick(2);
    `CHK("req_drop", 1'b0, req)
    `CHK("wake_pend", y, pend[IRQS[k]])
    if (y) src = src ^ EVS[k];
    pwr = IPW_RUN;
    on = 1'b1;
    wait_idle();
  endtask
  initial begin
    tick(8);
    arst_n = 1'b1;
    run = 1'b1;
    `CHK("reset", 291'h0, {pend, prio, nmi, req, tv})
    on = 1'b1;
    for (int k = 0; k < 12; k++) begin
      fire(k, 1'b0);
      fire(k, 1'b1);
    end
    src.nmi_pin_n = 1'b0;
    tick();
    src.nmi_pin_n = 1'b1;
    tick();
    `CHK("nmi", 1'b1, nmi)
    pw = '{1'b1, 5'h0a, 2'h3};
    exp_prio[87:86] = 2'h3;
    tick();
    `CHK("prio_10", 2'h3, prio[87:86])
    repeat (40) begin
      pw = 8'($random(seed));
      if (pw.en) exp_prio[fpos(pw.irq) +: 2] = pw.prio;
      tick();
      `CHK("prio", exp_prio, prio)
    end
    pw = 8'h00;
    wake(8, IPW_STOP, 1'b0, 1'b0, 1'b1);
    wake(9, IPW_VERY_LOW_POWER_STOP, 1'b0, 1'b0, 1'b1);
    wake(6, IPW_STOP, 1'b0, 1'b0, 1'b1);
    wake(11, IPW_STOP, 1'b0, 1'b0, 1'b0);
    wake(11, IPW_VERY_LOW_POWER_STOP, 1'b1, 1'b0, 1'b1);
    wake(1, IPW_STOP, 1'b1, 1'b0, 1'b1);
    wake(5, IPW_STOP, 1'b0, 1'b0, 1'b0);
    wake(10, IPW_DEEP, 1'b0, 1'b0, 1'b0);
    wake(10, IPW_STOP, 1'b0, 1'b0, 1'b1);
    wake(3, IPW_STOP, 1'b0, 1'b0, 1'b1);
    wake(0, IPW_STOP, 1'b0, 1'b0, 1'b1);
    wake(0, IPW_STOP, 1'b0, 1'b1, 1'b1);
    // Short pin pulse while stopped must stay latched until restart
    on = 1'b0;
    pwr = IPW_STOP;
    run = 1'b0;
    tick();
    gate = 1'b0;
    #20 src.nmi_pin_n = 1'b0;
    #10 src.nmi_pin_n = 1'b1;
    #10 gate = 1'b1;
    tick(3);
    `CHK("nmi_wake", 1'b1, req)
    run = 1'b1;
    pwr = IPW_RUN;
    on = 1'b1;
    tick(2);
    `CHK("nmi_drop", 1'b0, req)
    print_verdict();
  end
endmodule
`default_nettype wire
